// ---- verilog/ulfs_pkg.sv ----
// shared constants, types and helpers for the line format and status block
package ulfs_pkg;
  // register byte addresses
  localparam logic [7:0] ADDR_DATA = 8'h00;
  localparam logic [7:0] ADDR_IER = 8'h04;
  localparam logic [7:0] ADDR_FCR = 8'h08;
  localparam logic [7:0] ADDR_LCR = 8'h0c;
  localparam logic [7:0] ADDR_LSR = 8'h14;
  // interrupt enable bits
  localparam int IER_RX = 0;
  localparam int IER_TX = 1;
  localparam int IER_LS = 2;
  // queue control bits
  localparam int FCR_FME = 0;
  localparam int FCR_RFLUSH = 1;
  localparam int FCR_TFLUSH = 2;
  localparam int FCR_DME = 3;
  localparam int FCR_UME = 4;
  localparam int FCR_TRIG = 6;
  // reset values
  localparam logic [7:0] LCR_RST = 8'h00;
  localparam logic [7:0] IER_RST = 8'h00;
  localparam logic [7:0] DLL_RST = 8'h01;
  localparam logic [7:0] DLH_RST = 8'h00;
  // oversampling and stop lengths in sample ticks
  localparam int OVS = 16;
  localparam int OVS_LOG = 4;
  localparam int HALF = 8;
  localparam logic [5:0] STOP1_TICKS = 6'h10;
  localparam logic [5:0] STOP15_TICKS = 6'h18;
  localparam logic [5:0] STOP2_TICKS = 6'h20;

  typedef struct packed {
    logic divisor_select;
    logic force_break;
    logic fixed_parity;
    logic parity_sense;
    logic parity_enable;
    logic stop_bit_count;
    logic [1:0] character_length;
  } ulfs_fmt_t;

  typedef struct packed {
    logic brk;
    logic fe;
    logic pe;
    logic [7:0] data;
  } ulfs_rxent_t;

  typedef enum logic [2:0] {
    S_IDLE = 3'h0, S_START = 3'h1, S_DATA = 3'h3, S_PAR = 3'h2, S_STOP = 3'h6, S_HOLD = 3'h7
  } ulfs_state_t;

  function automatic logic [3:0] ulfs_nbits(input logic [1:0] len);
    return 4'h5 + {2'h0, len};
  endfunction

  function automatic logic ulfs_par(input ulfs_fmt_t f, input logic [7:0] d);
    logic [7:0] m;
    m = d & (8'hff >> (2'h3 - f.character_length));
    if (f.fixed_parity) return ~f.parity_sense;
    return f.parity_sense ? ^m : ~^m;
  endfunction

  function automatic logic [5:0] ulfs_stop_ticks(input ulfs_fmt_t f);
    if (!f.stop_bit_count) return STOP1_TICKS;
    if (f.character_length == 2'h0) return STOP15_TICKS;
    return STOP2_TICKS;
  endfunction

  function automatic logic [7:0] ulfs_char_ticks(input ulfs_fmt_t f);
    logic [7:0] n;
    n = {4'h0, ulfs_nbits(f.character_length)} + 8'h01 + {7'h0, f.parity_enable};
    return (n << OVS_LOG) + {2'h0, ulfs_stop_ticks(f)};
  endfunction

  function automatic logic [4:0] ulfs_trig(input logic [1:0] t);
    case (t)
      2'h0: return 5'h01;
      2'h1: return 5'h04;
      2'h2: return 5'h08;
      default: return 5'h0f;
    endcase
  endfunction
endpackage

// ---- verilog/ulfs_tx.sv ----
// transmit serialiser: start, data, optional parity, stop bits
`timescale 1ns/100ps
module ulfs_tx import ulfs_pkg::*; (
  input wire logic clk, // system clock
  input wire logic rst_n, // async reset
  input wire logic tick, // sample-rate enable
  input wire logic start, // load a character
  input wire logic [7:0] data, // character to send
  input wire ulfs_fmt_t fmt, // line format
  output logic busy, // shifter holds a character
  output logic ser // serial out before break forcing
);
  ulfs_state_t st_ff, nxt_st;
  logic [5:0] tc_ff, nxt_tc;
  logic [2:0] bit_ff, nxt_bit;
  logic [7:0] shf_ff, nxt_shf;
  logic par_ff, nxt_par, ser_ff, nxt_ser;
  wire [2:0] last_bit = 3'(ulfs_nbits(fmt.character_length) - 4'h1);
  wire bit_end = tick & (tc_ff == 6'(OVS - 1));
  wire stop_end = tick & (tc_ff == ulfs_stop_ticks(fmt) - 6'h01);

  assign busy = (st_ff != S_IDLE);
  assign ser = ser_ff;

  // bit sequencing, one bit per OVS ticks
  always_comb begin
    nxt_st = st_ff;
    nxt_tc = tick ? tc_ff + 6'h01 : tc_ff;
    nxt_bit = bit_ff;
    nxt_shf = shf_ff;
    nxt_par = par_ff;
    nxt_ser = ser_ff;
    case (st_ff)
      S_IDLE: begin
        nxt_tc = 6'h00;
        if (start) begin
          nxt_st = S_START;
          nxt_shf = data;
          nxt_par = ulfs_par(fmt, data);
          nxt_ser = 1'b0;
        end
      end
      S_START: if (bit_end) begin
        nxt_st = S_DATA;
        nxt_tc = 6'h00;
        nxt_bit = 3'h0;
        nxt_ser = shf_ff[0];
      end
      S_DATA: if (bit_end) begin
        nxt_tc = 6'h00;
        if (bit_ff == last_bit) begin
          nxt_st = fmt.parity_enable ? S_PAR : S_STOP;
          nxt_ser = fmt.parity_enable ? par_ff : 1'b1;
        end else begin
          nxt_bit = bit_ff + 3'h1;
          nxt_shf = shf_ff >> 1;
          nxt_ser = shf_ff[1];
        end
      end
      S_PAR: if (bit_end) begin
        nxt_st = S_STOP;
        nxt_tc = 6'h00;
        nxt_ser = 1'b1;
      end
      S_STOP: if (stop_end) begin
        nxt_st = S_IDLE;
        nxt_tc = 6'h00;
      end
      default: nxt_st = S_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_ff <= S_IDLE;
      tc_ff <= 6'h00;
      bit_ff <= 3'h0;
      shf_ff <= 8'h00;
      par_ff <= 1'b0;
      ser_ff <= 1'b1;
    end else begin
      st_ff <= nxt_st;
      tc_ff <= nxt_tc;
      bit_ff <= nxt_bit;
      shf_ff <= nxt_shf;
      par_ff <= nxt_par;
      ser_ff <= nxt_ser;
    end
  end
endmodule

// ---- verilog/ulfs_rx.sv ----
// receive deserialiser with parity, framing and break detection
`timescale 1ns/100ps
module ulfs_rx import ulfs_pkg::*; (
  input wire logic clk, // system clock
  input wire logic rst_n, // async reset
  input wire logic tick, // sample-rate enable
  input wire logic rxd, // serial in
  input wire ulfs_fmt_t fmt, // line format
  output logic done, // one-cycle character pulse
  output ulfs_rxent_t ent // character with its error bits
);
  ulfs_state_t st_ff, nxt_st;
  logic [5:0] tc_ff, nxt_tc;
  logic [2:0] bit_ff, nxt_bit;
  logic [7:0] shf_ff, nxt_shf, lowc_ff;
  logic pe_ff, nxt_pe, brk_ff, nxt_brk, done_ff, nxt_done;
  ulfs_rxent_t ent_ff, nxt_ent;
  wire [2:0] last_bit = 3'(ulfs_nbits(fmt.character_length) - 4'h1);
  wire bit_end = tick & (tc_ff == 6'(OVS - 1));

  assign done = done_ff;
  assign ent = ent_ff;

  // low-time counter for break, saturating
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) lowc_ff <= 8'h00;
    else if (rxd) lowc_ff <= 8'h00;
    else if (tick && lowc_ff != 8'hff) lowc_ff <= lowc_ff + 8'h01;
  end

  // sampling at bit centres
  always_comb begin
    nxt_st = st_ff;
    nxt_tc = tick ? tc_ff + 6'h01 : tc_ff;
    nxt_bit = bit_ff;
    nxt_shf = shf_ff;
    nxt_pe = pe_ff;
    nxt_brk = brk_ff;
    nxt_done = 1'b0;
    nxt_ent = ent_ff;
    case (st_ff)
      S_IDLE: begin
        nxt_tc = 6'h00;
        if (!rxd) nxt_st = S_START;
      end
      S_START: if (tick && tc_ff == 6'(HALF - 1)) begin
        nxt_st = rxd ? S_IDLE : S_DATA; // glitch rejects
        nxt_tc = 6'h00;
        nxt_bit = 3'h0;
        nxt_shf = 8'h00;
        nxt_pe = 1'b0;
      end
      S_DATA: if (bit_end) begin
        nxt_tc = 6'h00;
        nxt_shf[bit_ff] = rxd;
        nxt_bit = bit_ff + 3'h1;
        if (bit_ff == last_bit) nxt_st = fmt.parity_enable ? S_PAR : S_STOP;
      end
      S_PAR: if (bit_end) begin
        nxt_tc = 6'h00;
        nxt_pe = rxd ^ ulfs_par(fmt, shf_ff);
        nxt_st = S_STOP;
      end
      S_STOP: if (bit_end) begin
        // only the first stop bit is looked at
        nxt_tc = 6'h00;
        if (rxd) begin
          nxt_st = S_IDLE;
          nxt_done = 1'b1;
          nxt_ent = '{brk: 1'b0, fe: 1'b0, pe: pe_ff, data: shf_ff};
        end else begin
          nxt_st = S_HOLD;
        end
      end
      S_HOLD: begin
        // one character per break however long the line stays low
        if (!brk_ff && lowc_ff > ulfs_char_ticks(fmt)) begin
          nxt_brk = 1'b1;
          nxt_done = 1'b1;
          nxt_ent = '{brk: 1'b1, fe: 1'b1, pe: 1'b0, data: 8'h00};
        end
        if (rxd) begin
          nxt_st = S_IDLE;
          nxt_brk = 1'b0;
          if (!brk_ff) begin
            nxt_done = 1'b1;
            nxt_ent = '{brk: 1'b0, fe: 1'b1, pe: pe_ff, data: shf_ff};
          end
        end
      end
      default: nxt_st = S_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_ff <= S_IDLE;
      tc_ff <= 6'h00;
      bit_ff <= 3'h0;
      shf_ff <= 8'h00;
      pe_ff <= 1'b0;
      brk_ff <= 1'b0;
      done_ff <= 1'b0;
      ent_ff <= '0;
    end else begin
      st_ff <= nxt_st;
      tc_ff <= nxt_tc;
      bit_ff <= nxt_bit;
      shf_ff <= nxt_shf;
      pe_ff <= nxt_pe;
      brk_ff <= nxt_brk;
      done_ff <= nxt_done;
      ent_ff <= nxt_ent;
    end
  end
endmodule

// ---- verilog/ulfs_top.sv ----
// serial port line format, line status, queues and apb register slave
//
// The address map and the APB interface to the registers were chosen for this implementation.
`timescale 1ns/100ps
// How it works
// - divisor_select high maps shared addresses to divisor bytes, low to data and enables.
// - force_break holds the transmit pin low; the serialiser runs on untouched.
// - fixed parity sends the inverse of parity_sense, only when parity is on.
// - parity_sense zero means odd parity, one means even; ignored without parity.
// - parity_enable adds a parity bit on transmit and checks it on receive.
// - one stop bit, or two; with five-bit characters one and a half.
// - the receiver checks only the first stop bit.
// - character_length codes 0 to 3 give five to eight data bits.
// - error flags in line status bits 4:1 hold until status is read or the receive queue is flushed.
// - queue error is high while any queued character carries an error, FIFO mode only.
// - in DMA mode queue error raises the line interrupt and blocks receive DMA.
// - transmitter idle only when holding buffer and shifter are both empty.
// - space request when holding buffer empty, or at least half empty in FIFO mode.
// - space request with enable raises interrupt; in DMA without enable, a DMA request.
// - break flag when the input stays low beyond one character time; clears on read.
// - a break loads one zero character; flags describe the queue head.
// - framing error when the first stop bit is zero; head character; clears on read.
// - parity error for a wrong parity bit; head character; clears on status read.
// - lost data flag when a character arrives with the buffer full; clears on read.
// - data available while the buffer holds characters; flush or emptying clears it.
module ulfs_top import ulfs_pkg::*; #(
  parameter int RX_DEPTH = 16, // receive queue depth, power of two
  parameter int TX_DEPTH = 16 // transmit queue depth, power of two
) (
  input wire logic pclk, // 250 MHz bus clock
  input wire logic presetn, // async reset
  input wire logic psel, // apb select
  input wire logic penable, // apb enable
  input wire logic pwrite, // apb direction
  input wire logic [7:0] paddr, // apb byte address
  input wire logic [31:0] pwdata, // apb write data
  output logic [31:0] prdata, // apb read data
  output logic pready, // apb ready
  output logic pslverr, // apb error
  input wire logic rxd, // serial receive line
  output logic txd, // serial transmit line
  output logic irq, // combined interrupt request
  output logic tx_dma_req, // transmit dma request
  output logic rx_dma_req // receive dma request
);
  localparam int RAW = $clog2(RX_DEPTH);
  localparam int TAW = $clog2(TX_DEPTH);
  localparam int RCW = $clog2(RX_DEPTH + 1);
  localparam int TCW = $clog2(TX_DEPTH + 1);
  localparam logic [RCW-1:0] RX_FULL = RCW'(RX_DEPTH);
  localparam logic [TCW-1:0] TX_FULL = TCW'(TX_DEPTH);
  localparam logic [TCW-1:0] TX_HALF = TCW'(TX_DEPTH / 2);

  // software registers
  ulfs_fmt_t fmt_ff;
  logic [7:0] ier_ff, dll_ff, dlh_ff;
  logic fme_ff, dme_ff, ume_ff;
  logic [1:0] trig_ff;
  // baud divider
  logic [15:0] bdc_ff;
  logic tick_ff;
  // receive queue
  ulfs_rxent_t rq_ff [RX_DEPTH];
  logic [RAW-1:0] rwr_ff, rrd_ff;
  logic [RCW-1:0] rcnt_ff, qerr_ff;
  // transmit queue
  logic [7:0] tq_ff [TX_DEPTH];
  logic [TAW-1:0] twr_ff, trd_ff;
  logic [TCW-1:0] tcnt_ff;
  // status and bus outputs
  logic [3:0] lse_ff;
  logic [31:0] prdata_ff;
  logic pready_ff, pslverr_ff, txd_ff, irq_ff, txdma_ff, rxdma_ff;
  // engine wires
  logic tx_busy, tx_ser, rx_done;
  ulfs_rxent_t rx_ent;

  // apb phases; writes and read side effects land on the completing edge
  wire setup = psel & ~penable;
  wire fin = psel & penable & pready_ff;
  wire fin_wr = fin & pwrite;
  wire fin_rd = fin & ~pwrite;
  wire dsel = fmt_ff.divisor_select;
  wire a_data = (paddr == ADDR_DATA);
  wire a_ier = (paddr == ADDR_IER);
  wire a_fcr = (paddr == ADDR_FCR);
  wire a_lcr = (paddr == ADDR_LCR);
  wire a_lsr = (paddr == ADDR_LSR);
  wire hit = a_data | a_ier | a_fcr | a_lcr | a_lsr;

  // address sharing under divisor_select
  wire wr_thr = fin_wr & a_data & ~dsel;
  wire wr_dll = fin_wr & a_data & dsel;
  wire wr_ier = fin_wr & a_ier & ~dsel;
  wire wr_dlh = fin_wr & a_ier & dsel;
  wire wr_fcr = fin_wr & a_fcr;
  wire wr_lcr = fin_wr & a_lcr;
  wire rd_rbr = fin_rd & a_data & ~dsel;
  wire rd_lsr = fin_rd & a_lsr;
  wire rx_flush = wr_fcr & pwdata[FCR_RFLUSH];
  wire tx_flush = wr_fcr & pwdata[FCR_TFLUSH];

  // baud tick: one pulse per divisor count, a zero divisor acts as one
  wire [15:0] divisor = {dlh_ff, dll_ff};
  wire bd_wrap = (bdc_ff + 16'h0001 >= divisor);

  // receive queue; capacity is one character outside FIFO mode
  wire [RCW-1:0] rcap = fme_ff ? RX_FULL : RCW'(1);
  wire rx_full = (rcnt_ff >= rcap);
  wire rx_empty = (rcnt_ff == '0);
  wire rx_push = rx_done & ~rx_full & ~rx_flush;
  wire rx_lost = rx_done & rx_full;
  wire rx_pop = rd_rbr & ~rx_empty & ~rx_flush;
  wire [RAW-1:0] rrd_nx = rrd_ff + RAW'(1);
  ulfs_rxent_t head, head_nx;
  assign head = rq_ff[rrd_ff];
  // next character that becomes head, either queued or arriving
  assign head_nx = (rcnt_ff > RCW'(1)) ? rq_ff[rrd_nx] : rx_ent;
  wire new_head = (rx_push & rx_empty) | (rx_pop & ((rcnt_ff > RCW'(1)) | rx_push));
  wire push_err = rx_push & (rx_ent.brk | rx_ent.fe | rx_ent.pe);
  wire pop_err = rx_pop & (head.brk | head.fe | head.pe);
  wire qerr = fme_ff & (qerr_ff != '0);
  wire rx_lvl = fme_ff ? (rcnt_ff >= RCW'(ulfs_trig(trig_ff))) : ~rx_empty;

  // sticky error flags {break, framing, parity, lost}; a set beats a clear
  wire [3:0] lse_set = {new_head & head_nx.brk, new_head & head_nx.fe, new_head & head_nx.pe, rx_lost};
  wire [3:0] nxt_lse = (lse_ff & ~{4{rd_lsr}}) | lse_set;

  // transmit queue, same capacity rule as receive
  wire [TCW-1:0] tcap = fme_ff ? TX_FULL : TCW'(1);
  wire tx_full = (tcnt_ff >= tcap);
  wire tx_push = wr_thr & ~tx_full & ~tx_flush; // writes into a full queue are dropped
  wire tx_go = ~tx_busy & (tcnt_ff != '0) & ~tx_flush;
  wire tx_req = fme_ff ? (tcnt_ff <= TX_HALF) : (tcnt_ff == '0);
  wire tx_idle = (tcnt_ff == '0) & ~tx_busy;

  // status byte
  wire [7:0] lsr_val = {qerr, tx_idle, tx_req, lse_ff, ~rx_empty};
  // read mux; write-only registers read as zero
  wire [7:0] rd_val = (a_data & dsel) ? dll_ff :
                      (a_data & ~dsel) ? head.data :
                      (a_ier & dsel) ? dlh_ff :
                      (a_ier & ~dsel) ? ier_ff :
                      a_lsr ? lsr_val : 8'h00;

  // interrupt and dma terms
  wire ls_irq = ier_ff[IER_LS] & ((|lse_ff) | (dme_ff & qerr));
  wire rx_irq = ier_ff[IER_RX] & rx_lvl;
  wire tx_irq = ier_ff[IER_TX] & tx_req;
  wire nxt_txdma = dme_ff & ~ier_ff[IER_TX] & tx_req;
  wire nxt_rxdma = dme_ff & fme_ff & rx_lvl & ~qerr;

  ulfs_tx u_tx (
    .clk(pclk),
    .rst_n(presetn),
    .tick(tick_ff),
    .start(tx_go),
    .data(tq_ff[trd_ff]),
    .fmt(fmt_ff),
    .busy(tx_busy),
    .ser(tx_ser)
  );

  ulfs_rx u_rx (
    .clk(pclk),
    .rst_n(presetn),
    .tick(tick_ff),
    .rxd(rxd),
    .fmt(fmt_ff),
    .done(rx_done),
    .ent(rx_ent)
  );

  // configuration registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fmt_ff <= LCR_RST;
      ier_ff <= IER_RST;
      dll_ff <= DLL_RST;
      dlh_ff <= DLH_RST;
      {fme_ff, dme_ff, ume_ff} <= 3'h0;
      trig_ff <= 2'h0;
    end else begin
      if (wr_lcr) fmt_ff <= pwdata[7:0];
      if (wr_ier) ier_ff <= pwdata[7:0];
      if (wr_dll) dll_ff <= pwdata[7:0];
      if (wr_dlh) dlh_ff <= pwdata[7:0];
      if (wr_fcr) begin
        fme_ff <= pwdata[FCR_FME];
        dme_ff <= pwdata[FCR_DME];
        ume_ff <= pwdata[FCR_UME];
        trig_ff <= pwdata[FCR_TRIG +: 2];
      end
    end
  end

  // baud divider; halted while the port is disabled
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bdc_ff <= 16'h0000;
      tick_ff <= 1'b0;
    end else begin
      bdc_ff <= (!ume_ff || bd_wrap) ? 16'h0000 : bdc_ff + 16'h0001;
      tick_ff <= ume_ff & bd_wrap;
    end
  end

  // receive queue storage
  always_ff @(posedge pclk) begin
    if (rx_push) rq_ff[rwr_ff] <= rx_ent;
  end

  // receive pointers, level and error-character count
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rwr_ff <= '0;
      rrd_ff <= '0;
      rcnt_ff <= '0;
      qerr_ff <= '0;
    end else if (rx_flush) begin
      rwr_ff <= '0;
      rrd_ff <= '0;
      rcnt_ff <= '0;
      qerr_ff <= '0;
    end else begin
      if (rx_push) rwr_ff <= rwr_ff + RAW'(1);
      if (rx_pop) rrd_ff <= rrd_nx;
      rcnt_ff <= rcnt_ff + RCW'(rx_push) - RCW'(rx_pop);
      qerr_ff <= qerr_ff + RCW'(push_err) - RCW'(pop_err);
    end
  end

  // transmit queue storage
  always_ff @(posedge pclk) begin
    if (tx_push) tq_ff[twr_ff] <= pwdata[7:0];
  end

  // transmit pointers and level
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      twr_ff <= '0;
      trd_ff <= '0;
      tcnt_ff <= '0;
    end else if (tx_flush) begin
      twr_ff <= '0;
      trd_ff <= '0;
      tcnt_ff <= '0;
    end else begin
      if (tx_push) twr_ff <= twr_ff + TAW'(1);
      if (tx_go) trd_ff <= trd_ff + TAW'(1);
      tcnt_ff <= tcnt_ff + TCW'(tx_push) - TCW'(tx_go);
    end
  end

  // line status flags
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) lse_ff <= 4'h0;
    else if (rx_flush) lse_ff <= lse_set & 4'h1;
    else lse_ff <= nxt_lse;
  end

  // apb answer: ready in the cycle after setup, so no wait states
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_ff <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff <= 32'h0000_0000;
    end else begin
      pready_ff <= setup;
      pslverr_ff <= setup & ~hit;
      prdata_ff <= (setup & ~pwrite) ? {24'h000000, rd_val} : 32'h0000_0000;
    end
  end

  // pin and request outputs; break acts on the pin only
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      txd_ff <= 1'b1;
      irq_ff <= 1'b0;
      txdma_ff <= 1'b0;
      rxdma_ff <= 1'b0;
    end else begin
      txd_ff <= fmt_ff.force_break ? 1'b0 : tx_ser;
      irq_ff <= ls_irq | rx_irq | tx_irq;
      txdma_ff <= nxt_txdma;
      rxdma_ff <= nxt_rxdma;
    end
  end

  assign prdata = prdata_ff;
  assign pready = pready_ff;
  assign pslverr = pslverr_ff;
  assign txd = txd_ff;
  assign irq = irq_ff;
  assign tx_dma_req = txdma_ff;
  assign rx_dma_req = rxdma_ff;
endmodule

// ---- verif/ulfs_chk_checker.sv ----
// port assertions for the line format and status block
`timescale 1ns/100ps
module ulfs_chk import ulfs_pkg::*; (
  input wire logic pclk, // clock
  input wire logic presetn, // reset, low active
  input wire logic psel, // select
  input wire logic penable, // enable
  input wire logic pwrite, // write
  input wire logic [7:0] paddr, // address
  input wire logic [31:0] pwdata, // write data
  input wire logic [31:0] prdata, // read data
  input wire logic pready, // ready
  input wire logic pslverr, // error
  input wire logic txd, // serial out
  input wire logic tx_dma_req, // tx dma
  input wire logic rx_dma_req // rx dma
);
  default clocking dc @(posedge pclk); endclocking
  default disable iff (!presetn);
  // status read and break write, seen in their access cycle
  wire st = psel && penable && pready && !pwrite && paddr == ADDR_LSR;
  wire brk = psel && penable && pready && pwrite && paddr == ADDR_LCR && pwdata[6];
  AST_SETUP_READY: assert property (psel && !penable |=> pready) else $error("no ready");
  AST_READY_ONE: assert property (pready |=> !pready) else $error("ready held");
  AST_ERR_READY: assert property (pslverr |-> pready && prdata[31:8] == 24'h0) else $error("bad error");
  AST_BREAK_PIN: assert property (brk |-> ##[1:3] !txd) else $error("break not on pin");
  AST_IDLE_SPACE: assert property (st && prdata[6] |-> prdata[5]) else $error("idle without space");
  AST_QERR_AVAIL: assert property (st && prdata[7] |-> prdata[0]) else $error("error without data");
  AST_QERR_RXDMA: assert property (st && prdata[7] |-> !rx_dma_req) else $error("rx dma on error");
  AST_SPACE_TXDMA: assert property (st && !prdata[5] |-> !tx_dma_req) else $error("tx dma no space");
endmodule
bind ulfs_top ulfs_chk u_chk (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .txd(txd),
  .tx_dma_req(tx_dma_req), .rx_dma_req(rx_dma_req));

// ---- verif/ulfs_remote.sv ----
// remote serial partner: sends frames on rxd, decodes txd
`timescale 1ns/100ps
module ulfs_remote import ulfs_pkg::*; (
  input wire logic pclk, // clock
  input wire logic txd, // line from block
  input wire ulfs_fmt_t fmt, // decode format
  input wire logic en, // decode enable
  input wire logic send, // start a frame
  input wire logic [31:0] frame, // bits, bit 0 first
  input wire logic [5:0] len, // bits to send
  output logic rxd, // line to block
  output logic done, // char decoded
  output logic [8:0] word, // parity and data
  output logic [15:0] gap // cycles between starts
);
  int cyc = 0;
  int last = 0;
  initial begin
    rxd = 1'b1;
    done = 1'b0;
  end
  // sender, 16 clocks a bit at divisor one; mark level between frames
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (send) begin
      for (int i = 0; i < len; i++) begin
        rxd <= frame[i];
        repeat (16) @(posedge pclk);
      end
      rxd <= 1'b1;
    end
  end
  // decoder samples bit centres, lsb first; stop value left to the block
  always @(posedge pclk) if (en && txd === 1'b0) begin
    gap <= 16'(cyc - last);
    last = cyc;
    word = 9'h000;
    repeat (8) @(posedge pclk);
    for (int i = 0; i < 5 + fmt.character_length; i++) begin
      repeat (16) @(posedge pclk);
      word[i] = txd;
    end
    if (fmt.parity_enable) repeat (16) @(posedge pclk);
    if (fmt.parity_enable) word[8] = txd;
    repeat (16) @(posedge pclk);
    done <= 1'b1;
    @(posedge pclk);
    done <= 1'b0;
  end
endmodule

// ---- verif/ulfs_top_tb.sv ----
// self-checking bench for the line format and status block
`timescale 1ns/100ps
module ulfs_top_tb import ulfs_pkg::*;;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, send = 1'b0, en = 1'b0;
  logic [7:0] paddr = 8'h00, d, m, f;
  logic [31:0] pwdata = 32'h0, frame = 32'h0, prdata;
  logic [5:0] len = 6'h00;
  logic pready, pslverr, rxd, txd, irq, tx_dma_req, rx_dma_req, done;
  logic [8:0] word, sq[$];
  logic [15:0] gap;
  logic [32:0] rq[$];
  ulfs_fmt_t lfmt = '0;
  logic [7:0] fmts[8] = '{8'h00, 8'h07, 8'h04, 8'h0a, 8'h1b, 8'h39, 8'h2a, 8'h25};
  int err_total = 0, total_checks = 0, cyc = 0, seed = 6216, n, g;
  initial forever #2 pclk = ~pclk;
  ulfs_top u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .rxd(rxd), .txd(txd), .irq(irq),
    .tx_dma_req(tx_dma_req), .rx_dma_req(rx_dma_req));
  ulfs_remote u_far (.pclk(pclk), .txd(txd), .fmt(lfmt), .en(en), .send(send), .frame(frame), .len(len),
    .rxd(rxd), .done(done), .word(word), .gap(gap));
  task check(input logic [32:0] got, input logic [32:0] exp);
    total_checks++;
    if (got !== exp) begin
      err_total++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task wrap_up;
    check(sq.size() + rq.size(), 0);
    if (err_total == 0 && total_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  // apb master: setup, then access held until pready seen high
  task apb(input logic w, input logic [7:0] a, input logic [7:0] v, input logic [32:0] e);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, v};
    if (!w) rq.push_back(e);
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task wr(input logic [7:0] a, input logic [7:0] v);
    apb(1'b1, a, v, 33'h0);
  endtask
  task rd(input logic [7:0] a, input logic [7:0] e);
    apb(1'b0, a, 8'h00, {25'h0, e});
  endtask
  // one frame from the partner, then the line rests high
  task ser(input logic [31:0] fr, input logic [5:0] ln);
    @(posedge pclk);
    frame <= fr;
    len <= ln;
    send <= 1'b1;
    @(posedge pclk);
    send <= 1'b0;
    repeat (16 * ln + 40) @(posedge pclk);
  endtask
  // result watcher: oldest note against each answer
  always @(posedge pclk) begin
    if (psel && penable && pready === 1'b1 && !pwrite) check({pslverr, prdata}, rq.pop_front());
    if (done === 1'b1) check(word, sq.pop_front());
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      err_total++;
      wrap_up;
    end
  end
  initial begin
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    wr(ADDR_FCR, 8'h10);
    wr(ADDR_LCR, 8'h80);
    rd(ADDR_DATA, DLL_RST);
    rd(ADDR_IER, DLH_RST);
    wr(ADDR_LCR, 8'h03);
    wr(ADDR_IER, 8'h06);
    rd(ADDR_IER, 8'h06);
    check(irq, 1'b1);
    wr(ADDR_IER, 8'h00);
    apb(1'b0, 8'h10, 8'h00, {1'b1, 32'h0});
    rd(ADDR_LCR, 8'h00);
    // eight formats, two back-to-back characters; masked data, parity, spacing
    en <= 1'b1;
    foreach (fmts[i]) begin
      f = fmts[i];
      lfmt <= f;
      wr(ADDR_LCR, f);
      n = 5 + f[1:0];
      g = 16 * (2 + n + f[3]) + (f[2] ? (n == 5 ? 8 : 16) : 0);
      repeat (2) begin
        d = 8'($random(seed));
        m = d & (8'hff >> (8 - n));
        sq.push_back({f[3] & (f[5] ? ~f[4] : (f[4] ? ^m : ~^m)), m});
        wr(ADDR_DATA, d);
      end
      repeat (32 * (n + 5)) @(posedge pclk);
      check(gap >= g && gap <= g + 3, 1'b1);
    end
    // break only on the pin; shifter still drains
    en <= 1'b0;
    wr(ADDR_LCR, 8'h43);
    wr(ADDR_DATA, 8'h55);
    wr(ADDR_DATA, 8'haa);
    rd(ADDR_LSR, 8'h00);
    check(txd, 1'b0);
    repeat (400) @(posedge pclk);
    rd(ADDR_LSR, 8'h60);
    wr(ADDR_LCR, 8'h03);
    repeat (3) @(posedge pclk);
    check(txd, 1'b1);
    // single-buffer receive: good, overrun, parity, framing
    d = 8'($random(seed));
    ser({22'h3fffff, 1'b1, d, 1'b0}, 6'h0a);
    rd(ADDR_LSR, 8'h61);
    rd(ADDR_DATA, d);
    rd(ADDR_LSR, 8'h60);
    ser({22'h3fffff, 1'b1, d, 1'b0}, 6'h0a);
    ser({22'h3fffff, 1'b1, ~d, 1'b0}, 6'h0a);
    rd(ADDR_LSR, 8'h63);
    rd(ADDR_DATA, d);
    wr(ADDR_LCR, 8'h0b);
    ser({21'h1fffff, 1'b1, ^d, d, 1'b0}, 6'h0b);
    rd(ADDR_LSR, 8'h65);
    rd(ADDR_LSR, 8'h61);
    rd(ADDR_DATA, d);
    wr(ADDR_LCR, 8'h03);
    ser({22'h3fffff, 1'b0, d, 1'b0}, 6'h0a);
    rd(ADDR_LSR, 8'h69);
    rd(ADDR_DATA, d);
    // queue mode: a long break gives one zero character
    wr(ADDR_FCR, 8'h11);
    ser(32'h0, 6'h20);
    rd(ADDR_LSR, 8'hf9);
    rd(ADDR_LSR, 8'he1);
    rd(ADDR_DATA, 8'h00);
    rd(ADDR_LSR, 8'h60);
    ser({22'h3fffff, 1'b1, d, 1'b0}, 6'h0a);
    wr(ADDR_FCR, 8'h13);
    rd(ADDR_LSR, 8'h60);
    // dma mode: request routing and the queue error interrupt
    wr(ADDR_FCR, 8'h19);
    repeat (3) @(posedge pclk);
    check({tx_dma_req, rx_dma_req}, 2'b10);
    wr(ADDR_IER, 8'h06);
    repeat (3) @(posedge pclk);
    check({irq, tx_dma_req}, 2'b10);
    wr(ADDR_IER, 8'h04);
    ser(32'h0, 6'h20);
    rd(ADDR_LSR, 8'hf9);
    repeat (3) @(posedge pclk);
    check({irq, rx_dma_req}, 2'b10);
    rd(ADDR_DATA, 8'h00);
    repeat (3) @(posedge pclk);
    check({irq, rx_dma_req}, 2'b00);
    ser({22'h3fffff, 1'b1, d, 1'b0}, 6'h0a);
    check({irq, rx_dma_req}, 2'b01);
    wrap_up;
  end
endmodule
